// >>> common/pcss_consts.svh
/*
  Constants for the card socket signal control block: register offsets, field positions,
  reset values, input indices and strobe timing.
  Assumes it is included by bare name and that no other file defines the same macros.
*/
// Overview of operation
// - Memory write asserts the card write strobe low, outside DMA.
// - DMA read with I/O write strobe: write strobe follows terminal count high.
// - DMA write with I/O read strobe keeps the write strobe high.
// - Every socket I/O read asserts the I/O read strobe low.
// - Every socket I/O write asserts the I/O write strobe low.
// - Memory mode (type bit 5 zero): shared input is the write-protect switch.
// - I/O mode: low shared input means the address supports 16-bit transfers.
// - DMA mode: write-protect or input-acknowledge input is selectable as DMA request.
// - Memory mode: ready/busy input shows as status bit 5.
// - I/O mode: ready input is an active-low card interrupt request.
// - Wait held low stretches the access; it completes after wait returns high.
// - Card enables go low only during card access cycles.
// - First enable serves even bytes, second enable odd bytes.
// - 8-bit cards: only first enable active, address bit 0 set for odd bytes.
// - Card reset output high holds reset, low for normal operation.
// - Card reset is undriven unless card seated and interface enabled.
// - Register select picks attribute memory; active low for non-DMA I/O.
// - Memory read asserts the output-enable strobe low, outside DMA.
`ifndef PCSS_CONSTS_SVH
`define PCSS_CONSTS_SVH

`define PCSS_AW 12
`define PCSS_OFS_CTRL 12'h000
`define PCSS_OFS_CMD 12'h004
`define PCSS_OFS_STAT 12'h008

`define PCSS_CTRL_W 6
`define PCSS_CTRL_RST 6'h02
`define PCSS_C_SIGEN 0
`define PCSS_C_CRST 1
`define PCSS_C_BUS8 2
`define PCSS_C_DMA 3
`define PCSS_C_DRQSEL 4
`define PCSS_C_IOMODE 5

`define PCSS_K_LO 0
`define PCSS_K_HI 2
`define PCSS_M_ODD 3
`define PCSS_M_WORD 4
`define PCSS_M_ATTR 5
`define PCSS_M_TC 6

`define PCSS_S_BUSY 0
`define PCSS_S_SEAT 1
`define PCSS_S_CD1 2
`define PCSS_S_CD2 3
`define PCSS_S_WP 4
`define PCSS_S_RDY 5
`define PCSS_S_IREQ 6
`define PCSS_S_IO16 7
`define PCSS_S_ACK 8
`define PCSS_S_DREQ 9
`define PCSS_STAT_W 10

`define PCSS_NIN 6
`define PCSS_I_CD1 0
`define PCSS_I_CD2 1
`define PCSS_I_WP 2
`define PCSS_I_ACK 3
`define PCSS_I_RDY 4
`define PCSS_I_WAIT 5
`define PCSS_IN_RST 6'h3F

`define PCSS_CLK_NS 50
`define PCSS_STROBE_NS 300
`define PCSS_STROBE_CYC ((`PCSS_STROBE_NS + `PCSS_CLK_NS - 1) / `PCSS_CLK_NS)
`define PCSS_CNT_W 4

`endif

// >>> common/pcss_pkg.sv
/*
  Types of the card socket signal control block: cycle state and cycle kind.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pcss_pkg;

  // Gray codes along idle, setup, strobe, hold and back.
  typedef enum logic [1:0] {
    PCSS_IDLE = 2'h0,
    PCSS_SETUP = 2'h1,
    PCSS_ACTIVE = 2'h3,
    PCSS_HOLD = 2'h2
  } pcss_state_t;

  // DMA read moves memory data to the card with the I/O write strobe, DMA write the reverse.
  typedef enum logic [2:0] {
    PCSS_MEM_RD = 3'h0,
    PCSS_MEM_WR = 3'h1,
    PCSS_IO_RD = 3'h2,
    PCSS_IO_WR = 3'h3,
    PCSS_DMA_RD = 3'h4,
    PCSS_DMA_WR = 3'h5
  } pcss_kind_t;

endpackage : pcss_pkg

// >>> common/pcss_sync_if.sv
/*
  Carrier between the socket control top and its input synchroniser.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pcss_consts.svh"

interface pcss_sync_if;
  logic [`PCSS_NIN-1:0] raw;
  logic [`PCSS_NIN-1:0] clean;

  modport owner (output raw, input clean);
  modport sync (input raw, output clean);
endinterface : pcss_sync_if

`default_nettype wire

// >>> verilog/pcss_in_sync.sv
/*
  Synchroniser for the socket inputs: a three flip-flop chain per bit, and a new level counts
  once the second and third agree.
  Assumes the raw inputs are asynchronous to pclk and idle high, as pulled-up pins do.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pcss_consts.svh"

module pcss_in_sync (
  input wire logic pclk,
  input wire logic presetn,
  pcss_sync_if.sync sb
);

  genvar gi;

  // One chain per input; the first stage feeds only the second.
  generate
    for (gi = 0; gi < `PCSS_NIN; gi = gi + 1) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic clean_q;

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q <= 1'b1;
          s2_q <= 1'b1;
          s3_q <= 1'b1;
        end else begin
          s1_q <= sb.raw[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end

      // Holding on disagreement filters one-cycle glitches out of the card pins.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          clean_q <= 1'b1;
        end else if (s2_q == s3_q) begin
          clean_q <= s3_q;
        end
      end

      assign sb.clean[gi] = clean_q;
    end
  endgenerate

endmodule : pcss_in_sync

`default_nettype wire

// >>> verilog/pcss_socket_ctrl.sv
/*
  Socket signal control: APB register slave, card strobe sequencer, byte-lane enables,
  card reset drive and sensing of the card status inputs.
  Assumes an APB master on pclk and socket inputs that are asynchronous and pulled high.
*/
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "pcss_consts.svh"

module pcss_socket_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PCSS_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] card_det_n,
  input wire logic wp_io16_n,
  input wire logic in_ack_n,
  input wire logic rdy_irq_n,
  input wire logic wait_n,
  output logic card_we_n,
  output logic card_oe_n,
  output logic card_iord_n,
  output logic card_iowr_n,
  output logic card_reg_n,
  output logic [1:0] card_ce_n,
  output logic card_a0,
  output logic strobe_oe,
  output logic card_reset,
  output logic card_reset_oe,
  output logic card_irq,
  output logic card_dreq
);

  localparam logic [`PCSS_CNT_W-1:0] STROBE_CYC = `PCSS_CNT_W'(`PCSS_STROBE_CYC);

  pcss_sync_if sb ();
  logic [`PCSS_CTRL_W-1:0] ctrl_q;
  pcss_pkg::pcss_state_t st_q;
  pcss_pkg::pcss_kind_t kind_q;
  logic odd_q;
  logic word_q;
  logic attr_q;
  logic tc_q;
  logic [`PCSS_CNT_W-1:0] cnt_q;
  logic io16_q;
  logic ack_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic wr_acc;
  logic setup_ph;
  logic hit;
  logic seated;
  logic sig_en;
  logic io_mode;
  logic bus8;
  logic dreq_sel;
  logic cmd_go;
  logic [`PCSS_STAT_W-1:0] stat;

  assign sb.raw = {wait_n, rdy_irq_n, in_ack_n, wp_io16_n, card_det_n};

  pcss_in_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .sb(sb)
  );

  // Both detect pins low means seated; one low is a card still sliding in.
  assign seated = !sb.clean[`PCSS_I_CD1] && !sb.clean[`PCSS_I_CD2];
  assign sig_en = ctrl_q[`PCSS_C_SIGEN];
  assign io_mode = ctrl_q[`PCSS_C_IOMODE];
  assign bus8 = ctrl_q[`PCSS_C_BUS8];
  assign dreq_sel = ctrl_q[`PCSS_C_DRQSEL];

  // Bus phase decode.
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite && pready_q;
  assign hit = (paddr == `PCSS_OFS_CTRL) || (paddr == `PCSS_OFS_CMD) ||
               (paddr == `PCSS_OFS_STAT);
  assign cmd_go = wr_acc && (paddr == `PCSS_OFS_CMD) && (st_q == pcss_pkg::PCSS_IDLE) &&
                  seated && sig_en;

  // Status view: the shared inputs read by meaning of the selected card mode.
  always_comb begin
    stat = '0;
    stat[`PCSS_S_BUSY] = (st_q != pcss_pkg::PCSS_IDLE);
    stat[`PCSS_S_SEAT] = seated;
    stat[`PCSS_S_CD1] = sb.clean[`PCSS_I_CD1];
    stat[`PCSS_S_CD2] = sb.clean[`PCSS_I_CD2];
    stat[`PCSS_S_WP] = !io_mode && sb.clean[`PCSS_I_WP];
    stat[`PCSS_S_RDY] = !io_mode && sb.clean[`PCSS_I_RDY];
    stat[`PCSS_S_IREQ] = io_mode && !sb.clean[`PCSS_I_RDY];
    stat[`PCSS_S_IO16] = io16_q;
    stat[`PCSS_S_ACK] = ack_q;
    stat[`PCSS_S_DREQ] = card_dreq;
  end

  // Zero-wait slave: the answer is set up during the setup phase so it comes from flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= setup_ph;
      pslverr_q <= setup_ph && !hit;
      if (setup_ph && !pwrite) begin
        if (paddr == `PCSS_OFS_CTRL) begin
          prdata_q <= {{(32 - `PCSS_CTRL_W){1'b0}}, ctrl_q};
        end else if (paddr == `PCSS_OFS_STAT) begin
          prdata_q <= {{(32 - `PCSS_STAT_W){1'b0}}, stat};
        end else begin
          prdata_q <= '0;
        end
      end
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  // Control register; the reset bit starts set so a new card stays in reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `PCSS_CTRL_RST;
    end else if (wr_acc && (paddr == `PCSS_OFS_CTRL)) begin
      ctrl_q <= pwdata[`PCSS_CTRL_W-1:0];
    end
  end

  // A command is latched only when idle; commands while busy or unseated are dropped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kind_q <= pcss_pkg::PCSS_MEM_RD;
      odd_q <= 1'b0;
      word_q <= 1'b0;
      attr_q <= 1'b0;
      tc_q <= 1'b0;
    end else if (cmd_go) begin
      kind_q <= pcss_pkg::pcss_kind_t'(pwdata[`PCSS_K_HI:`PCSS_K_LO]);
      odd_q <= pwdata[`PCSS_M_ODD];
      word_q <= pwdata[`PCSS_M_WORD];
      attr_q <= pwdata[`PCSS_M_ATTR];
      tc_q <= pwdata[`PCSS_M_TC];
    end
  end

  // Sequencer: one setup cycle, a minimum strobe width, stretch on wait, one hold cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= pcss_pkg::PCSS_IDLE;
      cnt_q <= '0;
    end else begin
      unique case (st_q)
        pcss_pkg::PCSS_IDLE: begin
          if (cmd_go) begin
            st_q <= pcss_pkg::PCSS_SETUP;
          end
        end
        pcss_pkg::PCSS_SETUP: begin
          st_q <= pcss_pkg::PCSS_ACTIVE;
          cnt_q <= STROBE_CYC - `PCSS_CNT_W'(1);
        end
        pcss_pkg::PCSS_ACTIVE: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - `PCSS_CNT_W'(1);
          end else if (sb.clean[`PCSS_I_WAIT] || !seated) begin
            st_q <= pcss_pkg::PCSS_HOLD;
          end
        end
        pcss_pkg::PCSS_HOLD: begin
          st_q <= pcss_pkg::PCSS_IDLE;
        end
      endcase
    end
  end

  // I/O sizing and acknowledge are caught at the end of the strobe for software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io16_q <= 1'b0;
      ack_q <= 1'b0;
    end else if (st_q == pcss_pkg::PCSS_HOLD) begin
      io16_q <= io_mode && !sb.clean[`PCSS_I_WP];
      ack_q <= (kind_q == pcss_pkg::PCSS_IO_RD) && !sb.clean[`PCSS_I_ACK];
    end
  end

  // Strobes: registered from the state, so they trail it by one clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_we_n <= 1'b1;
      card_oe_n <= 1'b1;
      card_iord_n <= 1'b1;
      card_iowr_n <= 1'b1;
    end else begin
      card_we_n <= 1'b1;
      card_oe_n <= 1'b1;
      card_iord_n <= 1'b1;
      card_iowr_n <= 1'b1;
      if (st_q == pcss_pkg::PCSS_ACTIVE) begin
        unique case (kind_q)
          pcss_pkg::PCSS_MEM_RD: card_oe_n <= 1'b0;
          pcss_pkg::PCSS_MEM_WR: card_we_n <= 1'b0;
          pcss_pkg::PCSS_IO_RD: card_iord_n <= 1'b0;
          pcss_pkg::PCSS_IO_WR: card_iowr_n <= 1'b0;
          pcss_pkg::PCSS_DMA_RD: begin
            card_iowr_n <= 1'b0;
            card_we_n <= !tc_q;
          end
          pcss_pkg::PCSS_DMA_WR: begin
            card_iord_n <= 1'b0;
            card_oe_n <= !tc_q;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Byte lanes held from setup through hold; 8-bit cards use only the first enable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_ce_n <= 2'h3;
      card_a0 <= 1'b0;
      card_reg_n <= 1'b1;
    end else if (st_q == pcss_pkg::PCSS_IDLE) begin
      card_ce_n <= 2'h3;
      card_a0 <= 1'b0;
      card_reg_n <= 1'b1;
    end else begin
      if (bus8) begin
        card_ce_n <= 2'h2;
        card_a0 <= odd_q;
      end else if (word_q && !(io_mode && sb.clean[`PCSS_I_WP])) begin
        card_ce_n <= 2'h0;
        card_a0 <= 1'b0;
      end else begin
        card_ce_n <= odd_q ? 2'h1 : 2'h2;
        card_a0 <= odd_q;
      end
      if (kind_q == pcss_pkg::PCSS_DMA_RD || kind_q == pcss_pkg::PCSS_DMA_WR) begin
        card_reg_n <= 1'b1;
      end else if (io_mode) begin
        card_reg_n <= 1'b0;
      end else begin
        card_reg_n <= !attr_q;
      end
    end
  end

  // Reset and drive enables; reset floats unless seated and enabled to avoid glitches.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_reset <= 1'b1;
      card_reset_oe <= 1'b0;
      strobe_oe <= 1'b0;
    end else begin
      card_reset <= ctrl_q[`PCSS_C_CRST];
      card_reset_oe <= seated && sig_en;
      strobe_oe <= seated && sig_en;
    end
  end

  // Card interrupt and DMA request decode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_irq <= 1'b0;
      card_dreq <= 1'b0;
    end else begin
      card_irq <= io_mode && seated && !sb.clean[`PCSS_I_RDY];
      card_dreq <= ctrl_q[`PCSS_C_DMA] && seated &&
                   !(dreq_sel ? sb.clean[`PCSS_I_ACK] : sb.clean[`PCSS_I_WP]);
    end
  end

  AST_WE_MEMWR: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == pcss_pkg::PCSS_ACTIVE && kind_q == pcss_pkg::PCSS_MEM_WR) |=> !card_we_n)
    else $error("Write strobe missing on memory write.");
  AST_WE_TC: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == pcss_pkg::PCSS_ACTIVE && kind_q == pcss_pkg::PCSS_DMA_RD && tc_q)
      |=> (!card_we_n && !card_iowr_n))
    else $error("Terminal count not passed on DMA read.");
  AST_WE_DMAWR: assert property (@(posedge pclk) disable iff (!presetn)
    (kind_q == pcss_pkg::PCSS_DMA_WR && !card_iord_n) |-> card_we_n)
    else $error("Write strobe low during DMA write.");
  AST_IORD: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == pcss_pkg::PCSS_ACTIVE && kind_q == pcss_pkg::PCSS_IO_RD) |=> !card_iord_n)
    else $error("I/O read strobe missing.");
  AST_IOWR: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == pcss_pkg::PCSS_ACTIVE && kind_q == pcss_pkg::PCSS_IO_WR) |=> !card_iowr_n)
    else $error("I/O write strobe missing.");
  AST_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == pcss_pkg::PCSS_ACTIVE && cnt_q == '0 && !sb.clean[`PCSS_I_WAIT] && seated)
      |=> (st_q == pcss_pkg::PCSS_ACTIVE))
    else $error("Access ended while wait was low.");
  AST_CE_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == pcss_pkg::PCSS_IDLE && $past(st_q) == pcss_pkg::PCSS_IDLE) |=> card_ce_n == 2'h3)
    else $error("Card enable active outside an access.");
  AST_BUS8: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == pcss_pkg::PCSS_ACTIVE && bus8) |=> (card_ce_n == 2'h2 && card_a0 == odd_q))
    else $error("Second enable used on an 8-bit card.");
  AST_RST_OE: assert property (@(posedge pclk) disable iff (!presetn)
    (!seated || !sig_en) |=> !card_reset_oe)
    else $error("Card reset driven without a seated, enabled card.");
  AST_OE_MEMRD: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == pcss_pkg::PCSS_ACTIVE && kind_q == pcss_pkg::PCSS_MEM_RD) |=> !card_oe_n)
    else $error("Output enable missing on memory read.");
  AST_MIN_STROBE: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == pcss_pkg::PCSS_SETUP) |=> (st_q == pcss_pkg::PCSS_ACTIVE) [*6])
    else $error("Strobe shorter than its minimum width.");

endmodule : pcss_socket_ctrl

`default_nettype wire

// >>> verification/pcss_card_model.sv
/*
  Behavioural model of an inserted card seen from the socket pins.
  Assumes the bench sets insertion, status levels and wait length between card cycles.
*/
`timescale 1ns/100ps
`default_nettype none

module pcss_card_model (
  input wire logic pclk,
  input wire logic [1:0] det_lvl,
  input wire logic wp_lvl,
  input wire logic rdy_lvl,
  input wire logic ack_en,
  input wire logic ack_force,
  input wire logic [3:0] wait_len,
  input wire logic card_we_n,
  input wire logic card_oe_n,
  input wire logic card_iord_n,
  input wire logic card_iowr_n,
  output logic [1:0] card_det_n,
  output logic wp_io16_n,
  output logic in_ack_n,
  output logic rdy_irq_n,
  output logic wait_n
);
  logic strb_q = 1'b0;
  logic [3:0] wcnt = 4'h0;
  logic strb_any;

  // An absent contact floats to its pull-up, so the bench level already models it.
  assign card_det_n = det_lvl;
  assign wp_io16_n = wp_lvl;
  assign rdy_irq_n = rdy_lvl;
  // Acknowledge only while the read strobe is low, unless a DMA request is forced.
  assign in_ack_n = ~((ack_en & ~card_iord_n) | ack_force);
  assign strb_any = ~(card_we_n & card_oe_n & card_iord_n & card_iowr_n);
  // Wait falls with the strobe, as a real card answers at once, then holds for the set
  // count; a wait raised a clock late would miss the controller's synchroniser window.
  assign wait_n = ~((strb_any & ~strb_q & (wait_len != 4'h0)) | (wcnt != 4'h0));

  // Wait counter, restarted at each new strobe.
  always_ff @(posedge pclk) begin
    strb_q <= strb_any;
    if (strb_any && !strb_q) begin
      wcnt <= wait_len;
    end else if (wcnt != 4'h0) begin
      wcnt <= wcnt - 4'h1;
    end
  end
endmodule : pcss_card_model

`default_nettype wire

// >>> verification/pc_card_socket_signal_control_test.sv
/*
  Self-checking bench for the socket signal control block with a card model.
  Assumes the register offsets and field positions of the shared constants header.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pcss_consts.svh"

module pc_card_socket_signal_control_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, rnd;
  logic [1:0] card_det_n, card_ce_n, det_lvl, ce_and;
  logic wp_io16_n, in_ack_n, rdy_irq_n, wait_n, card_we_n, card_oe_n, card_iord_n;
  logic card_iowr_n, card_reg_n, card_a0, strobe_oe, card_reset, card_reset_oe;
  logic card_irq, card_dreq, wp_lvl, rdy_lvl, ack_en, ack_force, err, mon, a0s, regs;
  logic [3:0] wait_len, seen;
  int bad_count, n_checks, cyc, lowcnt;

  pcss_socket_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .card_det_n(card_det_n), .wp_io16_n(wp_io16_n), .in_ack_n(in_ack_n),
    .rdy_irq_n(rdy_irq_n), .wait_n(wait_n), .card_we_n(card_we_n), .card_oe_n(card_oe_n),
    .card_iord_n(card_iord_n), .card_iowr_n(card_iowr_n), .card_reg_n(card_reg_n),
    .card_ce_n(card_ce_n), .card_a0(card_a0), .strobe_oe(strobe_oe), .card_reset(card_reset),
    .card_reset_oe(card_reset_oe), .card_irq(card_irq), .card_dreq(card_dreq));
  pcss_card_model card (.pclk(pclk), .det_lvl(det_lvl), .wp_lvl(wp_lvl), .rdy_lvl(rdy_lvl),
    .ack_en(ack_en), .ack_force(ack_force), .wait_len(wait_len), .card_we_n(card_we_n),
    .card_oe_n(card_oe_n), .card_iord_n(card_iord_n), .card_iowr_n(card_iowr_n),
    .card_det_n(card_det_n), .wp_io16_n(wp_io16_n), .in_ack_n(in_ack_n),
    .rdy_irq_n(rdy_irq_n), .wait_n(wait_n));

  // Free-running bus clock.
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Watch the socket during a card cycle; strobe lows are accumulated by AND.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count = bad_count + 1;
      tally_and_finish();
    end
    if (mon) begin
      seen = seen & {card_we_n, card_oe_n, card_iord_n, card_iowr_n};
      ce_and = ce_and & card_ce_n;
      if (card_we_n & card_oe_n & card_iord_n & card_iowr_n) begin
      end else begin
        lowcnt = lowcnt + 1;
      end
      if (card_ce_n != 2'h3) begin
        a0s = card_a0;
        regs = card_reg_n;
      end
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // Strobes expected to fall, in the order we, oe, iord, iowr, high meaning low seen.
  function automatic logic [3:0] exp_strb(input logic [2:0] k, input logic tc);
    return {k == 3'h1 || (k == 3'h4 && tc), k == 3'h0 || (k == 3'h5 && tc),
      k == 3'h2 || k == 3'h5, k == 3'h3 || k == 3'h4};
  endfunction : exp_strb

  // Lane enables and address bit 0 expected for a cycle.
  function automatic logic [2:0] exp_lane(input logic b8, input logic io, input logic io16n,
    input logic odd, input logic word);
    if (b8) return {2'h2, odd};
    if (word && (!io || !io16n)) return 3'h0;
    return odd ? 3'h3 : 3'h4;
  endfunction : exp_lane

  task automatic check(input string name, input logic [31:0] seen_v, input logic [31:0] exp_v);
    n_checks = n_checks + 1;
    if (seen_v !== exp_v) begin
      bad_count = bad_count + 1;
      $display("[ERR] %s expected %h seen %h", name, exp_v, seen_v);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Wait for the socket inputs to pass the synchroniser, then read the status.
  task automatic settle_stat();
    repeat (8) @(posedge pclk);
    apb(1'b0, `PCSS_OFS_STAT, 32'h0);
  endtask : settle_stat

  task automatic run_cycle(input logic [2:0] k, input logic [5:0] c, input logic [3:0] f);
    logic [2:0] lane;
    int t;
    lane = exp_lane(c[2], c[5], wp_lvl, f[0], f[1]);
    seen = 4'hF;
    ce_and = 2'h3;
    lowcnt = 0;
    t = 0;
    mon = 1'b1;
    apb(1'b1, `PCSS_OFS_CMD, {25'h0, f, k});
    do begin
      apb(1'b0, `PCSS_OFS_STAT, 32'h0);
      t = t + 1;
    end while (rd[0] !== 1'b0 && t < 40);
    mon = 1'b0;
    check("strobes", {28'h0, ~seen}, exp_strb(k, f[3]));
    check("ce_idle", card_ce_n, 2'h3);
    check("io16", rd[7], c[5] && !wp_lvl);
    if (k < 3'h6) begin
      check("lanes", {ce_and, a0s}, lane);
      check("reg_sel", regs, k > 3'h3 ? 1'b1 : (c[5] ? 1'b0 : !f[2]));
      if (wait_len == 4'h0) check("width", lowcnt, 6);
    end
    if (k == 3'h2) check("ack_seen", rd[8], ack_en);
  endtask : run_cycle

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence: reset, detection, status inputs, DMA request, random card cycles.
  initial begin
    {psel, penable, pwrite, paddr, pwdata, mon, ack_en, ack_force} = '0;
    {det_lvl, wp_lvl, rdy_lvl, wait_len} = 8'hFF;
    wait_len = 4'h0;
    bad_count = 0;
    n_checks = 0;
    cyc = 0;
    rnd = 32'h0001745A;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("rst_out", {card_reset, card_reset_oe, card_ce_n}, 4'hB);
    apb(1'b0, 12'h0FC, 32'h0);
    check("unmapped", err, 1'b1);
    apb(1'b1, `PCSS_OFS_CTRL, 32'h3);
    for (int i = 3; i >= 0; i--) begin
      det_lvl <= i[1:0];
      settle_stat();
      check("seat", rd[3:1], {i[1:0], i == 0});
      check("rst_oe", card_reset_oe, i == 0);
      check("strb_oe", strobe_oe, i == 0);
    end
    check("rst_hold", card_reset, 1'b1);
    apb(1'b1, `PCSS_OFS_CTRL, 32'h1);
    repeat (2) @(posedge pclk);
    check("rst_run", {card_reset, card_reset_oe}, 2'h1);
    for (int j = 0; j < 4; j++) begin
      rdy_lvl <= j[0];
      wp_lvl <= j[1];
      settle_stat();
      check("mem_stat", rd[5:4], {j[0], j[1]});
    end
    apb(1'b1, `PCSS_OFS_CTRL, 32'h21);
    for (int j = 0; j < 2; j++) begin
      rdy_lvl <= j[0];
      settle_stat();
      check("irq", card_irq, !j[0]);
    end
    apb(1'b1, `PCSS_OFS_CTRL, 32'h29);
    for (int j = 0; j < 4; j++) begin
      if (j == 2) apb(1'b1, `PCSS_OFS_CTRL, 32'h39);
      wp_lvl <= j > 1 ? 1'b1 : j[0];
      ack_force <= j > 1 ? !j[0] : 1'b0;
      settle_stat();
      check("dreq", card_dreq, !j[0]);
    end
    ack_force <= 1'b0;
    for (int n = 0; n < 16; n++) begin
      rnd = lfsr_next(rnd);
      apb(1'b1, `PCSS_OFS_CTRL, {26'h0, n[3], 2'h0, rnd[7], rnd[0], 1'b1});
      wp_lvl <= rnd[1];
      ack_en <= rnd[2];
      settle_stat();
      run_cycle(n[2:0], {n[3], 2'h0, rnd[7], rnd[0], 1'b1}, rnd[6:3]);
    end
    apb(1'b1, `PCSS_OFS_CTRL, 32'h1);
    wait_len <= 4'hA;
    run_cycle(3'h0, 6'h01, 4'h0);
    check("stretch", lowcnt >= 13 && lowcnt <= 18, 1'b1);
    tally_and_finish();
  end
endmodule : pc_card_socket_signal_control_test

`default_nettype wire
